/* src/nvacc_top.sv */
// Purpose: Serial access and protection engine of a 512-byte memory.
// Assumes: Link pins are asynchronous to i_clk and far slower than it.
// Notes: Guard bits are not touched by i_rst_b, they model retention.
`timescale 1ns/1ps
// Overview of operation
// - Write-protect low at a byte's first bit refuses that byte's write
// - Status: bits 3:2 guard, 1 latch, rest zero
// - Guard bits survive resets
// - Only permit sets the latch; revoke, status write and write end clear it
// - Guard field selects protected address range
// - Writes need latch set and protect high
// - Address increments per byte, wraps
// - Each byte committed after eighth clock
// - Select rising ends a write
// - Protect change affects only following array bytes
// - Read shifts data out MSB first
// - Select rising ends a read
// - Pause suspends without abort
// - Status write needs protect high, latch set
// - Eight command bytes decoded for six commands
// - Completed write clears the latch
// - Sample on rise, drive on fall, MSB first
module nvacc_top #(
    parameter int DEPTH = nvacc_pkg::FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_cs_b,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_hold_b,
    input wire logic i_wp_b,
    output logic o_so,
    output logic o_so_oe
);
    import nvacc_pkg::*;
    localparam int FW = ADDR_W + DATA_W;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [4:0] sync1;
    logic [4:0] sync2;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            // Idle pin levels, so no false edge or pause follows reset.
            sync1 <= 5'h13;
            sync2 <= 5'h13;
        end else begin
            sync1 <= {i_cs_b, i_sck, i_si, i_hold_b, i_wp_b};
            sync2 <= sync1;
        end
    end
    logic cs_s, sck_s, si_s, held, wp_s;
    assign {cs_s, sck_s, si_s} = sync2[4:2];
    assign held = !sync2[1];
    assign wp_s = sync2[0];

    function automatic logic guarded(input logic [1:0] g,
                                     input logic [8:0] a);
        unique case (g)
            GUARD_NONE: guarded = 1'b0;
            GUARD_QUARTER: guarded = (a >= QUARTER_BASE);
            GUARD_HALF: guarded = (a >= HALF_BASE);
            default: guarded = 1'b1;
        endcase
    endfunction : guarded

    // ****************************************
    // Engine state
    // ****************************************
    nvacc_state_e state, next_state;
    logic sck_q, next_sck_q;
    logic cs_act, next_cs_act;
    logic [2:0] bitcnt, next_bitcnt;
    logic [7:0] in_sh, next_in_sh;
    logic [7:0] out_sh, next_out_sh;
    logic [8:0] addr, next_addr;
    logic write_permit_latch, next_wel;
    logic byte_ok, next_byte_ok;
    logic so, next_so;
    logic so_oe, next_so_oe;
    logic [1:0] guard = GUARD_RESET;
    logic [1:0] next_guard;
    logic [7:0] mem [MEM_WORDS];
    logic rise, fall, cs_rise, cs_fall, byte_done, fetch;
    logic [7:0] rx_byte, status;

    nvacc_fifo_if #(.W(FW)) fi ();

    always_comb begin
        // pause gate: no pin event is seen while held.
        rise = !held && cs_act == 1'b0 && sck_s && !sck_q;
        fall = !held && cs_act == 1'b0 && !sck_s && sck_q;
        cs_rise = !held && cs_s && !cs_act;
        cs_fall = !held && !cs_s && cs_act;
        byte_done = rise && bitcnt == LAST_BIT;
        rx_byte = {in_sh[6:0], si_s};
        status = '0;
        status[SR_GUARD_HI_POS] = guard[1];
        status[SR_GUARD_LO_POS] = guard[0];
        status[SR_PERMIT_POS] = write_permit_latch;
        next_state = state;
        next_sck_q = sck_s;
        next_cs_act = held ? cs_act : cs_s;
        next_bitcnt = bitcnt;
        next_in_sh = in_sh;
        next_out_sh = out_sh;
        next_addr = addr;
        next_wel = write_permit_latch;
        next_byte_ok = byte_ok;
        next_so = so;
        next_so_oe = so_oe;
        next_guard = guard;
        fetch = 1'b0;
        fi.push_valid = 1'b0;
        fi.push_data = {addr, rx_byte};
        if (rise) begin
            next_in_sh = rx_byte;
            next_bitcnt = bitcnt + 3'h1;
            if (bitcnt == 3'h0) begin
                next_byte_ok = wp_s;
            end
        end
        if (fall && (state == ST_RDATA || state == ST_SR_RD)) begin
            next_so = out_sh[7];
            next_so_oe = 1'b1;
            next_out_sh = {out_sh[6:0], 1'b0};
        end
        if (held) begin
            next_so_oe = 1'b0;
        end else if (!so_oe && state inside {ST_RDATA, ST_SR_RD}
                     && bitcnt != 3'h0) begin
            next_so_oe = 1'b1;
        end
        if (byte_done) begin
            unique case (state)
                ST_CMD: begin
                    next_state = ST_DONE;
                    if (rx_byte == OP_PERMIT) begin
                        next_wel = 1'b1;
                    end else if (rx_byte == OP_REVOKE) begin
                        next_wel = 1'b0;
                    end else if (rx_byte == OP_FETCH_SR) begin
                        next_out_sh = status;
                        next_state = ST_SR_RD;
                    end else if (rx_byte == OP_STORE_SR) begin
                        next_state = ST_SR_WR;
                    end else if ((rx_byte & OP_ARRAY_MASK) == OP_READ ||
                                 (rx_byte & OP_ARRAY_MASK) == OP_WRITE) begin
                        next_addr[8] = rx_byte[OP_ADDR_HI_POS];
                        // The idle output shifter keeps the opcode.
                        next_out_sh = rx_byte;
                        next_state = ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    next_addr[7:0] = rx_byte;
                    if (out_sh[0]) begin
                        fetch = 1'b1;
                        next_out_sh = mem[{addr[8], rx_byte}];
                        next_addr = {addr[8], rx_byte} + 9'h1;
                        next_state = ST_RDATA;
                    end else begin
                        next_state = ST_WDATA;
                    end
                end
                ST_WDATA: begin
                    fi.push_valid = byte_ok && write_permit_latch &&
                        !guarded(guard, addr) && fi.push_ready;
                    next_addr = addr + 9'h1;
                end
                ST_RDATA: begin
                    fetch = 1'b1;
                    next_out_sh = mem[addr];
                    next_addr = addr + 9'h1;
                end
                ST_SR_WR: begin
                    if (byte_ok && wp_s && write_permit_latch) begin
                        next_guard = rx_byte[SR_GUARD_HI_POS:
                                             SR_GUARD_LO_POS];
                        next_wel = 1'b0;
                    end
                    next_state = ST_DONE;
                end
                default: begin
                end
            endcase
        end
        if (cs_rise) begin
            if (state == ST_WDATA) begin
                next_wel = 1'b0;
            end
            next_state = ST_IDLE;
            next_so_oe = 1'b0;
        end else if (cs_fall) begin
            next_state = ST_CMD;
            next_bitcnt = 3'h0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= ST_IDLE;
            sck_q <= 1'b0;
            cs_act <= 1'b1;
            bitcnt <= 3'h0;
            in_sh <= 8'h00;
            out_sh <= 8'h00;
            addr <= 9'h000;
            write_permit_latch <= 1'b0;
            byte_ok <= 1'b0;
            so <= 1'b0;
            so_oe <= 1'b0;
        end else begin
            state <= next_state;
            sck_q <= next_sck_q;
            cs_act <= next_cs_act;
            bitcnt <= next_bitcnt;
            in_sh <= next_in_sh;
            out_sh <= next_out_sh;
            addr <= next_addr;
            write_permit_latch <= next_wel;
            byte_ok <= next_byte_ok;
            so <= next_so;
            so_oe <= next_so_oe;
        end
    end

    // ****************************************
    // Retained storage
    // ****************************************
    // guard bits kept through reset
    always_ff @(posedge i_clk) begin
        guard <= next_guard;
    end

    // The array drain pauses on a read fetch so the FIFO can back up.
    assign fi.pop_ready = !fetch;
    always_ff @(posedge i_clk) begin
        if (fi.pop_valid && fi.pop_ready) begin
            mem[fi.pop_data[FW-1:DATA_W]] <= fi.pop_data[DATA_W-1:0];
        end
    end

    nvacc_fifo #(.W(FW), .DEPTH(DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .f(fi)
    );

    assign o_so = so;
    assign o_so_oe = so_oe;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_cs_rise;
        cs_rise;
    endsequence
    property p_wp_block;
        @(posedge i_clk) disable iff (!i_rst_b)
        (rise && bitcnt == 3'h0) |=> byte_ok == $past(wp_s);
    endproperty
    a_wp_block: assert property (p_wp_block)
        else $error("protect not latched at first bit");
    property p_guard;
        @(posedge i_clk) disable iff (!i_rst_b)
        fi.push_valid |-> !guarded(guard, fi.push_data[FW-1:DATA_W]);
    endproperty
    a_guard: assert property (p_guard)
        else $error("write into guarded range");
    property p_permit;
        @(posedge i_clk) disable iff (!i_rst_b)
        fi.push_valid |-> write_permit_latch && byte_ok;
    endproperty
    a_permit: assert property (p_permit)
        else $error("write without permit latch");
    property p_latch_set;
        @(posedge i_clk) disable iff (!i_rst_b)
        $rose(write_permit_latch) |-> $past(state == ST_CMD && byte_done &&
                             rx_byte == OP_PERMIT);
    endproperty
    a_latch_set: assert property (p_latch_set)
        else $error("latch set without permit command");
    property p_addr_inc;
        @(posedge i_clk) disable iff (!i_rst_b)
        (byte_done && state == ST_WDATA && !cs_rise)
            |=> addr == $past(addr) + 9'h1;
    endproperty
    a_addr_inc: assert property (p_addr_inc)
        else $error("address did not advance");
    property p_end_op;
        @(posedge i_clk) disable iff (!i_rst_b)
        s_cs_rise |=> state == ST_IDLE && !so_oe;
    endproperty
    a_end_op: assert property (p_end_op)
        else $error("deselect did not end operation");
    property p_hold;
        @(posedge i_clk) disable iff (!i_rst_b)
        held |=> state == $past(state) && addr == $past(addr);
    endproperty
    a_hold: assert property (p_hold)
        else $error("state moved during pause");
    property p_sr_clear;
        @(posedge i_clk) disable iff (!i_rst_b)
        (byte_done && state == ST_SR_WR && wp_s && byte_ok && write_permit_latch)
            |=> !write_permit_latch ##0 state == ST_DONE;
    endproperty
    a_sr_clear: assert property (p_sr_clear)
        else $error("status write left latch set");
    property p_status_rd;
        @(posedge i_clk) disable iff (!i_rst_b)
        (byte_done && state == ST_CMD && rx_byte == OP_FETCH_SR)
            |=> out_sh[7:4] == 4'h0 && !out_sh[0] &&
                out_sh[SR_PERMIT_POS] == $past(write_permit_latch);
    endproperty
    a_status_rd: assert property (p_status_rd)
        else $error("status byte layout wrong");
endmodule : nvacc_top

/* src/nvacc_pkg.sv */
// Purpose: Shared constants for the serial nonvolatile access block.
// Assumes: 512 bytes, 9-bit address, 8-bit serial groups.
// Notes: Opcode bit 3 carries address bit 8 for array commands.
package nvacc_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int MEM_WORDS = 512;
    localparam int FIFO_DEPTH = 8;
    localparam int SYNC_STAGES = 2;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // Opcodes; array commands are matched with bit 3 masked off.
    localparam logic [7:0] OP_PERMIT = 8'h06;
    localparam logic [7:0] OP_REVOKE = 8'h04;
    localparam logic [7:0] OP_FETCH_SR = 8'h05;
    localparam logic [7:0] OP_STORE_SR = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_ARRAY_MASK = 8'hF7;
    localparam int OP_ADDR_HI_POS = 3;
    // Status layout.
    localparam int SR_GUARD_HI_POS = 3;
    localparam int SR_GUARD_LO_POS = 2;
    localparam int SR_PERMIT_POS = 1;
    localparam logic [1:0] GUARD_RESET = 2'h0;
    // Guarded regions by guard field.
    localparam logic [1:0] GUARD_NONE = 2'h0;
    localparam logic [1:0] GUARD_QUARTER = 2'h1;
    localparam logic [1:0] GUARD_HALF = 2'h2;
    localparam logic [8:0] QUARTER_BASE = 9'h180;
    localparam logic [8:0] HALF_BASE = 9'h100;
    typedef enum logic [2:0] {
        ST_IDLE, ST_CMD, ST_ADDR, ST_WDATA, ST_RDATA, ST_SR_RD,
        ST_SR_WR, ST_DONE
    } nvacc_state_e;
endpackage : nvacc_pkg

/* src/nvacc_fifo_if.sv */
// Purpose: Carrier between the access engine and its write FIFO.
// Assumes: Both ends on one clock.
// Notes: Valid/ready handshake on each side.
`timescale 1ns/1ps
interface nvacc_fifo_if #(parameter int W = 17) ();
    logic push_valid;
    logic push_ready;
    logic [W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [W-1:0] pop_data;
    modport fifo (input push_valid, push_data, pop_ready,
        output push_ready, pop_valid, pop_data);
    modport user (output push_valid, push_data, pop_ready,
        input push_ready, pop_valid, pop_data);
endinterface : nvacc_fifo_if

/* src/nvacc_fifo.sv */
// Purpose: Small synchronous FIFO holding committed array writes.
// Assumes: Depth is a power of two.
// Notes: Full and empty come from an extra pointer bit.
`timescale 1ns/1ps
module nvacc_fifo #(
    parameter int W = 17,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    nvacc_fifo_if.fifo f
);
    import nvacc_pkg::*;
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    logic full;
    logic empty;
    logic do_push;
    logic do_pop;

    always_comb begin
        full = (wr_ptr[AW] != rd_ptr[AW]) &&
            (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
        empty = (wr_ptr == rd_ptr);
        do_push = f.push_valid && !full;
        do_pop = f.pop_ready && !empty;
        next_wr_ptr = wr_ptr + (AW+1)'(do_push);
        next_rd_ptr = rd_ptr + (AW+1)'(do_pop);
        f.push_ready = !full;
        f.pop_valid = !empty;
        f.pop_data = mem[rd_ptr[AW-1:0]];
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    always_ff @(posedge i_clk) begin
        if (do_push) begin
            mem[wr_ptr[AW-1:0]] <= f.push_data;
        end
    end

    property p_no_overflow;
        @(posedge i_clk) disable iff (!i_rst_b)
        full |=> (wr_ptr == $past(wr_ptr)) || $past(do_pop);
    endproperty
    a_no_overflow: assert property (p_no_overflow)
        else $error("fifo pointer moved while full");
endmodule : nvacc_fifo

/* tb/nvacc_host.sv */
// Purpose: Serial bus master model that drives the access block's link.
// Assumes: Mode 0, clock idle low, four system clocks per half period.
// Notes: Data in carries a pattern even where the device must ignore it.
`timescale 1ns/1ps
module nvacc_host (
    input wire logic i_clk,
    input wire logic i_so,
    input wire logic i_so_oe,
    output logic o_cs_b,
    output logic o_sck,
    output logic o_si,
    output logic o_hold_b
);
    // ****************************************
    // Link driving tasks
    // ****************************************
    logic hold_oe;

    initial begin
        o_cs_b = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        o_hold_b = 1'b1;
        hold_oe = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick

    task automatic sel(input logic on);
        tick(4);
        o_cs_b = ~on;
        tick(on ? 4 : 8);
    endtask : sel

    task automatic xfer(input logic [7:0] d, input int nb, input int hb,
                        output logic [7:0] q);
        q = 8'h00;
        for (int i = 0; i < nb; i++) begin
            o_si = d[7-i];
            if (i == hb) begin
                // pause with clock low, after the last fall is seen
                tick(4);
                o_hold_b = 1'b0;
                tick(8);
                hold_oe = i_so_oe;
                o_sck = 1'b1;
                tick(4);
                o_sck = 1'b0;
                tick(4);
                o_hold_b = 1'b1;
            end
            tick(4);
            o_sck = 1'b1;
            tick(2);
            q = {q[6:0], i_so};
            tick(2);
            o_sck = 1'b0;
        end
    endtask : xfer
endmodule : nvacc_host

/* tb/tb_nvacc_top.sv */
// Purpose: Self-checking bench for the serial access and protect block.
// Assumes: Array locations are only read back after being written.
// Notes: Expected memory and status are tracked beside the device.
`timescale 1ns/1ps
module tb_nvacc_top;
    import nvacc_pkg::*;
    // ****************************************
    // Bench state
    // ****************************************
    logic clk, rst_b, wp_b, cs_b, sck, si, hold_b, so, so_oe, write_permit_latch;
    logic [1:0] g;
    logic [7:0] q;
    logic [7:0] mem [0:511];
    logic [8:0] probe [0:3] = '{9'h0FF, 9'h100, 9'h17F, 9'h180};
    int n_fail, check_count, cycles;

    nvacc_top #(.DEPTH(8)) dut (.i_clk(clk), .i_rst_b(rst_b),
        .i_cs_b(cs_b), .i_sck(sck), .i_si(si), .i_hold_b(hold_b),
        .i_wp_b(wp_b), .o_so(so), .o_so_oe(so_oe));
    nvacc_host host (.i_clk(clk), .i_so(so), .i_so_oe(so_oe),
        .o_cs_b(cs_b), .o_sck(sck), .o_si(si), .o_hold_b(hold_b));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic end_sim();
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    // A hung handshake would otherwise stall the run forever.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            end_sim();
        end
    end

    task automatic check(input string nm, input logic [7:0] s,
                         input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    function automatic logic guarded(input logic [1:0] f,
                                     input logic [8:0] a);
        return f == 2'h3 || (f == 2'h2 && a >= 9'h100) ||
            (f == 2'h1 && a >= 9'h180);
    endfunction : guarded

    // ****************************************
    // Command tasks
    // ****************************************
    task automatic desel();
        host.sel(1'b0);
        check("so_oe", {7'h00, so_oe}, 8'h00);
    endtask : desel

    task automatic op(input logic [7:0] c);
        host.sel(1'b1);
        host.xfer(c, 8, 9, q);
        desel();
        if (c == 8'h06) write_permit_latch = 1'b1;
        if (c == 8'h04) write_permit_latch = 1'b0;
    endtask : op

    task automatic sr_chk();
        host.sel(1'b1);
        host.xfer(8'h05, 8, 9, q);
        host.xfer(8'hA5, 8, 9, q);
        desel();
        check("status", q, {4'h0, g, write_permit_latch, 1'b0});
    endtask : sr_chk

    task automatic wsr(input logic [7:0] v);
        host.sel(1'b1);
        host.xfer(8'h01, 8, 9, q);
        host.xfer(v, 8, 9, q);
        desel();
        if (write_permit_latch && wp_b) begin
            g = v[3:2];
            write_permit_latch = 1'b0;
        end
    endtask : wsr

    // Protect is judged at the first bit of each byte, guard at its eighth.
    task automatic wr(input logic [8:0] a, input int n, input logic [7:0] d,
                      input int cut);
        host.sel(1'b1);
        host.xfer({4'h0, a[8], 3'h2}, 8, 9, q);
        host.xfer(a[7:0], 8, 9, q);
        for (int i = 0; i < n; i++) begin
            if (write_permit_latch && wp_b && !guarded(g, a)) mem[a] = d;
            host.xfer(d, 8, 9, q);
            a++;
            d = d + 8'h11;
        end
        if (cut > 0) host.xfer(~d, cut, 9, q);
        desel();
        write_permit_latch = 1'b0;
    endtask : wr

    task automatic rd(input logic [8:0] a, input int n, input int hb);
        host.sel(1'b1);
        host.xfer({4'h0, a[8], 3'h3}, 8, 9, q);
        host.xfer(a[7:0], 8, 9, q);
        for (int i = 0; i < n; i++) begin
            host.xfer(8'h5A ^ a[7:0], 8, hb, q);
            check("read data", q, mem[a]);
            check("so_oe on", {7'h00, so_oe}, 8'h01);
            a++;
        end
        desel();
    endtask : rd

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        rst_b = 1'b0;
        wp_b = 1'b1;
        n_fail = 0;
        check_count = 0;
        cycles = 0;
        g = 2'h0;
        write_permit_latch = 1'b0;
        repeat (5) @(posedge clk);
        #1 rst_b = 1'b1;
        host.tick(4);
        sr_chk();
        op(8'h06);
        sr_chk();
        op(8'h04);
        sr_chk();
        op(8'h06);
        wsr(8'hFF);
        sr_chk();
        for (int f = 0; f < 4; f++) begin
            op(8'h06);
            wsr({4'h0, f[1:0], 2'h0});
            for (int k = 0; k < 4; k++) begin
                op(8'h06);
                wr(probe[k], 1, {2'h0, f[1:0], k[1:0], 2'h1}, 0);
                rd(probe[k], 1, 9);
            end
        end
        op(8'h06);
        wsr(8'h00);
        op(8'h06);
        wr(9'h1FE, 4, 8'h3C, 0);
        rd(9'h1FE, 4, 3);
        check("hold so_oe", {7'h00, host.hold_oe}, 8'h00);
        // Protect pin low: status and array writes both refused.
        wp_b = 1'b0;
        op(8'h06);
        wsr(8'h0C);
        sr_chk();
        wr(9'h1FE, 1, 8'h77, 0);
        rd(9'h1FE, 1, 9);
        wp_b = 1'b1;
        sr_chk();
        // Protect drops inside the first data byte; the second is lost.
        op(8'h06);
        fork
            wr(9'h1FE, 2, 8'h81, 0);
            begin
                repeat (160) @(posedge clk);
                #1 wp_b = 1'b0;
            end
        join
        wp_b = 1'b1;
        rd(9'h1FE, 2, 9);
        op(8'h06);
        wr(9'h1FE, 1, 8'h42, 5);
        rd(9'h1FE, 2, 9);
        // Guard bits must outlive a reset in mid-run.
        op(8'h06);
        wsr(8'h04);
        host.tick(1);
        rst_b = 1'b0;
        host.tick(3);
        rst_b = 1'b1;
        write_permit_latch = 1'b0;
        host.tick(4);
        sr_chk();
        op(8'h06);
        wr(9'h1FF, 1, 8'hE7, 0);
        rd(9'h1FE, 2, 9);
        end_sim();
    end
endmodule : tb_nvacc_top
